// File: design/ctr_pkg.sv
// Shared constants and types of the counter flag and gate capture block
package ctr_pkg;
    // Geometry
    localparam int NCH        = 8;
    localparam int CNT_W      = 32;
    localparam int DEPTH_8CH  = 30000;
    localparam int DEPTH_16CH = 15000;
    localparam int AW         = 15;
    // Register byte offsets
    localparam logic [7:0] OFF_CMD     = 8'h00;
    localparam logic [7:0] OFF_REPLY   = 8'h04;
    localparam logic [7:0] OFF_FLAGS   = 8'h08;
    localparam logic [7:0] OFF_CUR     = 8'h0c;
    localparam logic [7:0] OFF_END     = 8'h10;
    localparam logic [7:0] OFF_PERIOD  = 8'h14;
    localparam logic [7:0] OFF_IRQ_ST  = 8'h18;
    localparam logic [7:0] OFF_IRQ_MSK = 8'h1c;
    localparam logic [7:0] OFF_MEM_ADR = 8'h20;
    localparam logic [7:0] OFF_MEM_DAT = 8'h24;
    // Reply register layout
    localparam int REPLY_KIND_LSB = 8;
    localparam int REPLY_VALID    = 15;
    // Interrupt status bits
    localparam int IRQ_REPLY   = 0;
    localparam int IRQ_OVF     = 1;
    localparam int IRQ_RUN_OUT = 2;
    localparam int IRQ_W       = 3;
    // Reset values
    localparam logic [CNT_W-1:0] PERIOD_RST = 32'h0000c34f;
    localparam logic [AW-1:0]    END_RST    = 15'h752f;

    typedef enum logic [3:0] {
        CMD_ACK_ON    = 4'h1,
        CMD_ACK_OFF   = 4'h2,
        CMD_ACK_QUERY = 4'h3,
        CMD_FLAG0     = 4'h4,
        CMD_FLAG1     = 4'h5,
        CMD_FLAG2     = 4'h6,
        CMD_FLAG3     = 4'h7,
        CMD_BEGIN_CNT = 4'h8,
        CMD_CAP_LEVEL = 4'h9,
        CMD_CAP_EDGE  = 4'ha,
        CMD_CAP_TIMER = 4'hb,
        CMD_STOP      = 4'hc,
        CMD_CLEAR     = 4'hd,
        CMD_SILENT_A  = 4'he,
        CMD_SILENT_B  = 4'hf
    } cmd_t;

    typedef enum logic [2:0] {
        REP_NONE = 3'h0,
        REP_OK   = 3'h1,
        REP_NG   = 3'h2,
        REP_DS   = 3'h3,
        REP_EN   = 3'h4,
        REP_DATA = 3'h5
    } reply_t;

    typedef enum logic [1:0] {
        CAP_OFF   = 2'h0,
        CAP_LEVEL = 2'h1,
        CAP_EDGE  = 2'h2,
        CAP_TIMER = 2'h3
    } cap_mode_t;
endpackage

// File: design/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Pins in, synchronised levels out
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);
    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } sync_t;

    sync_t s;
    sync_t next_s;

    // First stage is read only by the second
    always_comb begin
        next_s        = s;
        next_s.first  = pin_i;
        next_s.second = s.first;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign level_o = s.second;
endmodule

// File: design/capture_mem.sv
// Capture memory: one write port, one registered read port
`timescale 1ns/10ps
module capture_mem #(
    parameter int DW    = 32,
    parameter int DEPTH = 30000,
    parameter int AW    = 15
) (
    // Clock
    input  wire logic          clk_i,
    // Write port
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    // Read port
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);
    typedef struct packed {
        logic [DW-1:0] rdata;
    } rd_t;

    logic [DW-1:0] mem [DEPTH];
    rd_t s;
    rd_t next_s;

    always_comb begin
        next_s = s;
        if (32'(raddr_i) < DEPTH) begin
            next_s.rdata = mem[raddr_i];
        end else begin
            next_s.rdata = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        s <= next_s;
        if (we_i && 32'(waddr_i) < DEPTH) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    assign rdata_o = s.rdata;
endmodule

// File: design/counter_flags.sv
// Counter channels, command handling, flag groups and gate-timed capture
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
module counter_flags #(
    parameter int DEPTH = ctr_pkg::DEPTH_8CH
) (
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // Wishbone slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    // Interrupt
    output logic                         irq_o,
    // Pulse and control pins
    input  wire logic [ctr_pkg::NCH-1:0] pulse_i,
    input  wire logic                    gate_i,
    input  wire logic                    start_i,
    input  wire logic                    stop_i
);
    localparam int NCH   = ctr_pkg::NCH;
    localparam int CW    = ctr_pkg::CNT_W;
    localparam int AW    = ctr_pkg::AW;
    localparam int SYN_W = NCH + 3;

    typedef struct packed {
        logic [31:0]                 dat;
        logic                        ack;
        logic                        irq;
        logic                        ack_mode;
        logic                        counting;
        logic                        waiting_fall;
        ctr_pkg::cap_mode_t          mode;
        logic                        cap_run;
        logic                        busy;
        logic [2:0]                  ch_idx;
        logic [NCH-1:0][CW-1:0]      snap;
        logic [NCH-1:0][CW-1:0]      cnt;
        logic [NCH-1:0]              ovf;
        logic [CW-1:0]               tmr;
        logic                        tmr_ovf;
        logic                        run_out;
        logic [AW-1:0]               cur_addr;
        logic [AW-1:0]               end_addr;
        logic [CW-1:0]               period;
        logic [CW-1:0]               tick_cnt;
        logic                        gate_d;
        logic [NCH-1:0]              pulse_d;
        ctr_pkg::reply_t             reply_kind;
        logic [7:0]                  reply_byte;
        logic                        reply_valid;
        logic [ctr_pkg::IRQ_W-1:0]   irq_st;
        logic [ctr_pkg::IRQ_W-1:0]   irq_mask;
        logic [AW-1:0]               mem_addr;
    } state_t;

    state_t         s;
    state_t         next_s;
    logic [SYN_W-1:0] syn;
    logic [NCH-1:0] pulse_s;
    logic           gate_s;
    logic           start_s;
    logic           stop_s;
    logic [CW-1:0]  mem_rdata;

    pin_sync #(
        .W (SYN_W)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   ({stop_i, start_i, gate_i, pulse_i}),
        .level_o (syn)
    );

    assign pulse_s = syn[NCH-1:0];
    assign gate_s  = syn[NCH];
    assign start_s = syn[NCH+1];
    assign stop_s  = syn[NCH+2];

    capture_mem #(
        .DW    (CW),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_mem (
        .clk_i   (clk_i),
        .we_i    (s.busy),
        .waddr_i (s.cur_addr),
        .wdata_i (s.snap[s.ch_idx]),
        .raddr_i (s.mem_addr),
        .rdata_o (mem_rdata)
    );

    // Byte-lane merge of a bus write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = wr[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] flag_byte(input state_t st, input logic [1:0] grp,
                                             input logic g, input logic sta, input logic sto);
        logic [7:0] f;
        f = 8'h00;
        unique case (grp)
            2'd0: f[3:0] = st.ovf[3:0];
            2'd1: f[2:0] = st.ovf[6:4];
            2'd2: f[6:0] = {st.run_out, st.counting, st.tmr_ovf, st.ovf[7],
                            g, sto, sta};
            2'd3: f[2:1] = {st.cap_run && st.mode == ctr_pkg::CAP_EDGE,
                            st.cap_run && st.mode == ctr_pkg::CAP_LEVEL};
        endcase
        return f;
    endfunction

    always_comb begin
        logic            req;
        logic            rd_hit_reply;
        logic            rd_hit_irq;
        logic            cmd_go;
        logic            known;
        logic            silent;
        logic [3:0]      code;
        logic            cnt_en;
        logic            gate_fall;
        logic            tick;
        logic            capture_ev;
        logic [NCH-1:0]  rise;
        logic            ovf_ev;
        logic            run_out_ev;
        logic [31:0]     wv;
        logic [31:0]     rv;
        ctr_pkg::reply_t rk;
        logic [7:0]      rb;

        next_s       = s;
        req          = wb_cyc_i && wb_stb_i && !s.ack;
        rd_hit_reply = 1'b0;
        rd_hit_irq   = 1'b0;
        cmd_go       = 1'b0;
        known        = 1'b1;
        silent       = 1'b0;
        code         = wb_dat_i[3:0];
        ovf_ev       = 1'b0;
        run_out_ev   = 1'b0;
        wv           = 32'h0000_0000;
        rv           = 32'h0000_0000;
        rk           = ctr_pkg::REP_OK;
        rb           = 8'h00;
        cnt_en       = 1'b0;
        gate_fall    = 1'b0;
        tick         = 1'b0;
        capture_ev   = 1'b0;
        rise         = '0;
        next_s.ack   = req;
        next_s.gate_d  = gate_s;
        next_s.pulse_d = pulse_s;

        // Bus access; reads of reply and status clear, later sets override
        if (req) begin
            unique case (wb_adr_i)
                ctr_pkg::OFF_CMD: begin
                    cmd_go = wb_we_i && wb_sel_i[0];
                end
                ctr_pkg::OFF_REPLY: begin
                    rv = {16'h0000, s.reply_valid, 4'h0, s.reply_kind, s.reply_byte};
                    rd_hit_reply = !wb_we_i;
                end
                ctr_pkg::OFF_FLAGS: begin
                    for (int g = 0; g < 4; g++) begin
                        rv[8*g +: 8] = flag_byte(s, 2'(g), gate_s, start_s, stop_s);
                    end
                end
                ctr_pkg::OFF_CUR: begin
                    rv = 32'(s.cur_addr);
                    wv = merge(rv, wb_dat_i, wb_sel_i);
                    if (wb_we_i) next_s.cur_addr = wv[AW-1:0];
                end
                ctr_pkg::OFF_END: begin
                    rv = 32'(s.end_addr);
                    wv = merge(rv, wb_dat_i, wb_sel_i);
                    if (wb_we_i) next_s.end_addr = wv[AW-1:0];
                end
                ctr_pkg::OFF_PERIOD: begin
                    rv = s.period;
                    if (wb_we_i) next_s.period = merge(rv, wb_dat_i, wb_sel_i);
                end
                ctr_pkg::OFF_IRQ_ST: begin
                    rv = 32'(s.irq_st);
                    rd_hit_irq = !wb_we_i;
                end
                ctr_pkg::OFF_IRQ_MSK: begin
                    rv = 32'(s.irq_mask);
                    wv = merge(rv, wb_dat_i, wb_sel_i);
                    if (wb_we_i) next_s.irq_mask = wv[ctr_pkg::IRQ_W-1:0];
                end
                ctr_pkg::OFF_MEM_ADR: begin
                    rv = 32'(s.mem_addr);
                    wv = merge(rv, wb_dat_i, wb_sel_i);
                    if (wb_we_i) next_s.mem_addr = wv[AW-1:0];
                end
                ctr_pkg::OFF_MEM_DAT: begin
                    rv = mem_rdata;
                end
                default: begin
                    rv = 32'h0000_0000;
                end
            endcase
            next_s.dat = wb_we_i ? 32'h0000_0000 : rv;
        end
        if (rd_hit_reply) next_s.reply_valid = 1'b0;
        if (rd_hit_irq) next_s.irq_st = '0;

        // Command execution
        if (cmd_go) begin
            if (wb_dat_i[7:4] != 4'h0 || code == 4'h0) begin
                known = 1'b0;
            end else begin
                unique case (ctr_pkg::cmd_t'(code))
                    ctr_pkg::CMD_ACK_ON: begin
                        next_s.ack_mode = 1'b1;
                    end
                    ctr_pkg::CMD_ACK_OFF: begin
                        next_s.ack_mode = 1'b0;
                        silent = !s.ack_mode;
                    end
                    ctr_pkg::CMD_ACK_QUERY: begin
                        rk = s.ack_mode ? ctr_pkg::REP_EN : ctr_pkg::REP_DS;
                    end
                    ctr_pkg::CMD_FLAG0, ctr_pkg::CMD_FLAG1,
                    ctr_pkg::CMD_FLAG2, ctr_pkg::CMD_FLAG3: begin
                        rk = ctr_pkg::REP_DATA;
                        rb = flag_byte(s, code[1:0], gate_s, start_s, stop_s);
                    end
                    ctr_pkg::CMD_BEGIN_CNT: begin
                        next_s.counting     = 1'b1;
                        next_s.waiting_fall = s.mode == ctr_pkg::CAP_EDGE;
                        silent = !s.ack_mode;
                    end
                    ctr_pkg::CMD_CAP_LEVEL, ctr_pkg::CMD_CAP_EDGE,
                    ctr_pkg::CMD_CAP_TIMER: begin
                        next_s.mode     = ctr_pkg::cap_mode_t'(code[1:0]);
                        next_s.cap_run  = 1'b1;
                        next_s.run_out  = 1'b0;
                        next_s.tick_cnt = '0;
                        silent = !s.ack_mode;
                    end
                    ctr_pkg::CMD_STOP: begin
                        next_s.counting = 1'b0;
                        next_s.cap_run  = 1'b0;
                        next_s.busy     = 1'b0;
                        silent = !s.ack_mode;
                    end
                    ctr_pkg::CMD_CLEAR: begin
                        next_s.cnt     = '0;
                        next_s.ovf     = '0;
                        next_s.tmr     = '0;
                        next_s.tmr_ovf = 1'b0;
                        silent = !s.ack_mode;
                    end
                    default: begin
                        silent = !s.ack_mode;
                    end
                endcase
            end
            if (!known) begin
                rk = ctr_pkg::REP_NG;
            end
            if (!silent) begin
                next_s.reply_kind  = rk;
                next_s.reply_byte  = rb;
                next_s.reply_valid = 1'b1;
                next_s.irq_st[ctr_pkg::IRQ_REPLY] = 1'b1;
            end
        end

        // Counting
        gate_fall = s.gate_d && !gate_s;
        if (gate_fall && s.waiting_fall) begin
            next_s.waiting_fall = 1'b0;
        end
        unique case (s.mode)
            ctr_pkg::CAP_LEVEL: cnt_en = s.counting && gate_s;
            ctr_pkg::CAP_EDGE:  cnt_en = s.counting && !s.waiting_fall;
            default:            cnt_en = s.counting;
        endcase
        rise = pulse_s & ~s.pulse_d;
        for (int i = 0; i < NCH; i++) begin
            if (cnt_en && rise[i] && !(cmd_go && code == ctr_pkg::CMD_CLEAR)) begin
                if (&s.cnt[i]) begin
                    next_s.ovf[i] = 1'b1;
                    ovf_ev = 1'b1;
                end
                next_s.cnt[i] = s.cnt[i] + 1'b1;
            end
        end
        if (cnt_en && !(cmd_go && code == ctr_pkg::CMD_CLEAR)) begin
            if (&s.tmr) begin
                next_s.tmr_ovf = 1'b1;
                ovf_ev = 1'b1;
            end
            next_s.tmr = s.tmr + 1'b1;
        end

        // Capture timing
        if (s.cap_run && s.mode == ctr_pkg::CAP_TIMER) begin
            if (s.tick_cnt >= s.period) begin
                next_s.tick_cnt = '0;
                tick = 1'b1;
            end else begin
                next_s.tick_cnt = s.tick_cnt + 1'b1;
            end
        end
        capture_ev = s.cap_run && !s.busy &&
                     ((s.mode == ctr_pkg::CAP_TIMER) ? tick : gate_fall);
        if (capture_ev && next_s.cap_run) begin
            next_s.snap   = s.cnt;
            next_s.busy   = 1'b1;
            next_s.ch_idx = 3'h0;
        end

        // One word per cycle, channel order, successive addresses
        if (s.busy && next_s.busy) begin
            next_s.ch_idx = s.ch_idx + 3'h1;
            if (s.ch_idx == 3'(NCH - 1)) begin
                next_s.busy = 1'b0;
            end
            if (s.cur_addr == s.end_addr) begin
                next_s.busy    = 1'b0;
                next_s.cap_run = 1'b0;
                next_s.run_out = 1'b1;
                run_out_ev     = 1'b1;
            end else if (32'(s.cur_addr) >= DEPTH - 1) begin
                next_s.cur_addr = '0;
            end else begin
                next_s.cur_addr = s.cur_addr + 1'b1;
            end
        end

        // Sticky events win over the read-clear
        if (ovf_ev) next_s.irq_st[ctr_pkg::IRQ_OVF] = 1'b1;
        if (run_out_ev) next_s.irq_st[ctr_pkg::IRQ_RUN_OUT] = 1'b1;
        next_s.irq = |(next_s.irq_st & next_s.irq_mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s          <= '0;
            s.mode     <= ctr_pkg::CAP_OFF;
            s.end_addr <= ctr_pkg::END_RST;
            s.period   <= ctr_pkg::PERIOD_RST;
        end else begin
            s <= next_s;
        end
    end

    assign wb_dat_o = s.dat;
    assign wb_ack_o = s.ack;
    assign irq_o    = s.irq;
endmodule

// File: testbench/counter_flags_monitor.sv
// Bus timing and flag field checks for counter_flags
`timescale 1ns/10ps
module counter_flags_monitor #(
    parameter int DEPTH = 30000
) (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Bus and interrupt pins
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd(logic [7:0] a);
        s_req ##0 (!wb_we_i && wb_adr_i == a);
    endsequence
    property p_ack; s_req |=> wb_ack_o; endproperty
    property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_spur; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
    property p_grp1; s_rd(8'h08) |=> wb_dat_o[15:11] == 5'h0; endproperty
    property p_modes; s_rd(8'h08) |=> !(wb_dat_o[26] && wb_dat_o[25]); endproperty
    property p_kind; s_rd(8'h04) |=> wb_dat_o[10:8] <= 3'h5; endproperty
    property p_cur; s_rd(8'h0c) |=> wb_dat_o < DEPTH; endproperty
    property p_rst;
        disable iff (1'b0) rst_i |=> !wb_ack_o && !irq_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    a_pulse: assert property (p_pulse) else $error("ack too long");
    a_spur: assert property (p_spur) else $error("ack without request");
    a_grp1: assert property (p_grp1) else $error("group one upper bits set");
    a_modes: assert property (p_modes) else $error("two capture modes");
    a_kind: assert property (p_kind) else $error("bad reply kind");
    a_cur: assert property (p_cur) else $error("address past depth");
    a_rst: assert property (p_rst) else $error("outputs after reset");
endmodule

bind counter_flags counter_flags_monitor #(.DEPTH(DEPTH)) u_mon (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .irq_o    (irq_o)
);

// File: testbench/gate_source.sv
// External gate and pulse source for capture tests
`timescale 1ns/10ps
module gate_source #(
    parameter int HI = 64,
    parameter int LO = 49936
) (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    output logic            gate_o,
    output logic      [7:0] pulse_o
);
    logic [15:0] t = 16'h0;
    initial gate_o = 1'b0;
    initial pulse_o = 8'h0;
    // High plus low spans 1 ms at 50 MHz, so every store has its time
    always @(posedge clk_i) begin
        if (go_i)
            t <= 16'h1;
        else if (t != 16'h0)
            t <= (t == 16'(HI + LO)) ? 16'h0 : t + 16'h1;
        gate_o <= (t != 16'h0) && (t <= 16'(HI));
        for (int c = 0; c < 8; c++) begin
            // c+1 edges while high, four more while low
            pulse_o[c] <= t[1] && ((t >= 16'h8 && t < 16'(8 + 4 * (c + 1)))
                || (t >= 16'(HI + 8) && t < 16'(HI + 24)));
        end
    end
endmodule

// File: testbench/tb_counter_flags.sv
// Command, flag and gate capture tests for counter_flags
`timescale 1ns/10ps
module tb_counter_flags;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h0;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        irq_o;
    logic [7:0]  pulse_i;
    logic        gate_i;
    logic        start_i = 1'b0;
    logic        stop_i = 1'b0;
    logic        go = 1'b0;
    logic [31:0] q;
    int          err_total = 0;
    int          checked = 0;

    counter_flags #(.DEPTH(ctr_pkg::DEPTH_8CH)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .irq_o(irq_o), .pulse_i(pulse_i), .gate_i(gate_i), .start_i(start_i), .stop_i(stop_i));
    gate_source src (.clk_i(clk_i), .go_i(go), .gate_o(gate_i), .pulse_o(pulse_i));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Only the watchdog ends a wait that never sees ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic cmd(input logic [7:0] c);
        wb(1'b1, ctr_pkg::OFF_CMD, {24'h0, c});
        wb(1'b0, ctr_pkg::OFF_REPLY, 32'h0);
    endtask

    function automatic logic [31:0] rs();
        return {28'h0, q[15], q[10:8]};
    endfunction

    function automatic logic [31:0] rk(input logic [2:0] k);
        return {28'h0, 1'b1, k};
    endfunction

    initial begin
        repeat (60000) @(posedge clk_i);
        err_total++;
        end_sim;
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, ctr_pkg::OFF_FLAGS, 32'h0);
        chk(32'(q[26:25]), 32'h0);
        cmd(ctr_pkg::CMD_ACK_QUERY);
        chk(rs(), rk(ctr_pkg::REP_DS));
        cmd(ctr_pkg::CMD_SILENT_A);
        chk(32'(q[15]), 32'h0);
        cmd(ctr_pkg::CMD_ACK_ON);
        chk(rs(), rk(ctr_pkg::REP_OK));
        cmd(ctr_pkg::CMD_ACK_QUERY);
        chk(rs(), rk(ctr_pkg::REP_EN));
        for (int i = 14; i < 16; i++) begin
            cmd(8'(i));
            chk(rs(), rk(ctr_pkg::REP_OK));
        end
        for (int i = 0; i < 2; i++) begin
            cmd(i ? 8'h13 : 8'h00);
            chk(rs(), rk(ctr_pkg::REP_NG));
        end
        cmd(ctr_pkg::CMD_ACK_OFF);
        chk(rs(), rk(ctr_pkg::REP_OK));
        cmd(ctr_pkg::CMD_ACK_QUERY);
        chk(rs(), rk(ctr_pkg::REP_DS));
        for (int i = 0; i < 4; i++) begin
            start_i <= i[0];
            stop_i  <= i[1];
            repeat (4) @(posedge clk_i);
            wb(1'b0, ctr_pkg::OFF_FLAGS, 32'h0);
            chk(32'(q[17:16]), 32'(i));
        end
        cmd(ctr_pkg::CMD_FLAG2);
        chk({rs(), 6'h0, q[1:0]}, {rk(ctr_pkg::REP_DATA), 8'h3});
        wb(1'b1, ctr_pkg::OFF_CUR, 32'h0);
        wb(1'b1, ctr_pkg::OFF_END, 32'hf);
        cmd(ctr_pkg::CMD_CAP_LEVEL);
        wb(1'b0, ctr_pkg::OFF_FLAGS, 32'h0);
        chk(32'(q[26:25]), 32'h1);
        cmd(ctr_pkg::CMD_BEGIN_CNT);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i);
            go <= 1'b1;
            @(posedge clk_i);
            go <= 1'b0;
            repeat (k ? 140 : 50000) @(posedge clk_i);
        end
        wb(1'b0, ctr_pkg::OFF_FLAGS, 32'h0);
        chk(32'(q[26:21]), 32'h3);
        wb(1'b0, ctr_pkg::OFF_CUR, 32'h0);
        chk(q, 32'hf);
        // Timer capture: one tick every four cycles, one burst to the end address
        wb(1'b1, ctr_pkg::OFF_CUR, 32'h10);
        wb(1'b1, ctr_pkg::OFF_END, 32'h17);
        wb(1'b1, ctr_pkg::OFF_PERIOD, 32'h3);
        cmd(ctr_pkg::CMD_CAP_TIMER);
        repeat (20) @(posedge clk_i);
        wb(1'b0, ctr_pkg::OFF_CUR, 32'h0);
        chk(q, 32'h17);
        for (int i = 0; i < 24; i++) begin
            wb(1'b1, ctr_pkg::OFF_MEM_ADR, 32'(i));
            wb(1'b0, ctr_pkg::OFF_MEM_DAT, 32'h0);
            chk(q, 32'((i < 16 ? i / 8 + 1 : 2) * (i % 8 + 1)));
        end
        chk(32'(irq_o), 32'h0);
        wb(1'b1, ctr_pkg::OFF_IRQ_MSK, 32'h4);
        repeat (2) @(posedge clk_i);
        chk(32'(irq_o), 32'h1);
        wb(1'b0, ctr_pkg::OFF_IRQ_ST, 32'h0);
        chk(32'(q[2]), 32'h1);
        repeat (2) @(posedge clk_i);
        chk(32'(irq_o), 32'h0);
        cmd(ctr_pkg::CMD_CAP_EDGE);
        wb(1'b0, ctr_pkg::OFF_FLAGS, 32'h0);
        chk(32'(q[26:25]), 32'h2);
        cmd(ctr_pkg::CMD_STOP);
        wb(1'b0, ctr_pkg::OFF_FLAGS, 32'h0);
        chk(32'(q[26:25]), 32'h0);
        wb(1'b0, 8'h28, 32'h0);
        chk(q, 32'h0);
        end_sim;
    end
endmodule
